// ===== src/tssc_trigger_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tssc_trigger_ctrl
	import tssc_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// phase and transient engine
	input  wire logic [8:0]  phaseAccum,
	input  wire logic        extTrigger,
	input  wire logic        lastPointDone,
	input  wire logic        acqCalcDone,
	input  wire logic        devCmdPending,
	// common command byte stream
	input  wire logic        cmdByteValid,
	input  wire logic [7:0]  cmdByte,
	// outputs to engine
	output logic             transientStart,
	output logic             transientCancel,
	output logic             acqStart,
	output logic             triggerOut,
	output logic             busHold,
	output logic             commonCmdSeen,
	output logic             commonQuerySeen
);
	// ==========================================================
	// functions
	// a negative angle becomes its positive equivalent in 0..359
	function automatic logic [8:0] foldAngle(input logic signed [9:0] a);
		logic signed [10:0] t;
		t = {a[9], a};
		if (t < 0)
			t = t + 11'sd360;
		if (t >= 11'sd360)
			t = t - 11'sd360;
		return t[8:0];
	endfunction : foldAngle

	function automatic logic isLetter(input logic [7:0] c);
		return ((c >= 8'h41) && (c <= 8'h5a)) || ((c >= 8'h61) && (c <= 8'h7a));
	endfunction : isLetter

	// ==========================================================
	// state
	tssc_acq_t         acqSrc_r;
	logic              syncPhase_r;
	logic signed [9:0] phaseSet_r;
	tssc_state_t       tranSt_r, tranSt_nxt;
	logic              acqArmed_r, acqBusy_r;
	logic [8:0]        phasePrev_r;

	// ==========================================================
	// register map, one aligned 32-bit word each
	//   0x00 control: [1:0] acquisition source, [2] phase sync for transients
	//        source codes: 0 immediate, 1 phase locked, 2 bus, 3 trigger out
	//   0x04 phase: signed whole degrees, clamped to the legal span,
	//        read back sign-extended to the full word
	//   0x08 command, write only, every set bit is a one-cycle strobe:
	//        [0] initiate transient, [1] initiate acquisition, [2] abort,
	//        [3] bus trigger command, [4] software trigger, [5] group trigger
	//   0x0c status: [1:0] transient state, [3] acquisition armed,
	//        [4] acquisition busy, [5] bus held by the wait command
	//   0x10 common: write [0] to issue wait, read [0] shows the hold
	// unmapped offsets answer with an error, ignore writes and read zero.
	// several command bits in one write act together; abort always wins
	// over an initiate or a trigger carried in the same word, so software
	// can never leave a system armed by accident while cancelling it.
	// the command word reads back zero, since strobes leave no state.
	//
	// ==========================================================
	// apb decode
	wire apbWrite = psel && penable && pwrite;
	wire apbRead  = psel && penable && !pwrite;
	wire hitCtrl  = (paddr == ADDR_CTRL);
	wire hitPhase = (paddr == ADDR_PHASE);
	wire hitCmd   = (paddr == ADDR_CMD);
	wire hitStat  = (paddr == ADDR_STATUS);
	wire hitCom   = (paddr == ADDR_COMMON);
	wire mapped   = hitCtrl | hitPhase | hitCmd | hitStat | hitCom;
	wire cmdWr    = apbWrite && hitCmd;
	wire initTran = cmdWr && pwdata[CMD_INIT_TRAN];
	wire initAcq  = cmdWr && pwdata[CMD_INIT_ACQ];
	wire abortCmd = cmdWr && pwdata[CMD_ABORT];
	wire busTrg   = cmdWr && (pwdata[CMD_BUS_TRG] || pwdata[CMD_GET]);
	wire trigNow  = cmdWr && pwdata[CMD_TRIG_NOW];

	// phase write clamped to the legal range; the whole word is compared so
	// that a large value cannot alias into range once cut to ten bits
	wire signed [31:0] wrAngle      = pwdata;
	wire signed [31:0] clampWord    = (wrAngle > PHASE_MAX) ? 32'(PHASE_MAX) :
	                                  (wrAngle < PHASE_MIN) ? 32'(PHASE_MIN) : wrAngle;
	wire signed [9:0]  angleClamped = clampWord[9:0];

	// ==========================================================
	// phase detection notes
	// the accumulator may advance by more than one degree a cycle, so an
	// equality test alone could step over the target; instead the last and
	// the present values bracket the target, with a wrap through zero
	// handled as its own case. a negative setting names the same point of
	// the cycle as its positive twin, so it is folded once into 0..359 and
	// the compare only ever sees unsigned degrees. +360 and -360 fold to 0.
	// a stalled accumulator never reports a hit, which keeps one crossing
	// from firing twice while the phase source holds still.
	//
	// phase crossing: accumulator passes the target this cycle
	wire [8:0] target = foldAngle(phaseSet_r);
	wire phaseHit = (phasePrev_r != phaseAccum) &&
	                (((phasePrev_r < target) && (phaseAccum >= target)) ||
	                 ((phaseAccum < phasePrev_r) &&
	                  ((target > phasePrev_r) || (target <= phaseAccum))) ||
	                 (phaseAccum == target && phasePrev_r != target));

	// ==========================================================
	// trigger priority
	// when both systems wait on the bus source, every event is kept from the
	// transient; a bus or software event starts the acquisition, an external
	// one starts nothing, and the transient waits for the next. with the other
	// acquisition sources the transient sees every event, because those
	// sources do not consume trigger events at all. the trigger-out source
	// is fed by the registered start strobe, so a measurement tied to it
	// begins one cycle after the transient; this avoids a loop through
	// combinational logic at the price of a single cycle of latency.
	//
	// trigger events; acquisition on the bus source takes the first when both wait
	wire trigEvent = busTrg || extTrigger || trigNow;
	wire acqWaits  = acqArmed_r;
	wire acqFires  = acqArmed_r && (
	                 (acqSrc_r == ACQ_IMMEDIATE) ||
	                 (acqSrc_r == ACQ_PHASE_LOCKED_SOURCE && phaseHit) ||
	                 (acqSrc_r == ACQ_BUS && (busTrg || trigNow)) ||
	                 (acqSrc_r == ACQ_TRIGGER_OUT_SIGNAL_SOURCE && triggerOut));
	wire acqUsesEvent = acqWaits && (acqSrc_r == ACQ_BUS) && trigEvent;
	wire tranEvent = trigEvent && !acqUsesEvent;
	wire syncOk    = !syncPhase_r || phaseHit;

	// transient state machine
	always_comb begin
		tranSt_nxt = tranSt_r;
		case (tranSt_r)
			ST_IDLE:
				if (initTran)
					tranSt_nxt = ST_AWAITING_EVENT_STATE;
			ST_AWAITING_EVENT_STATE:
				if (tranEvent)
					tranSt_nxt = syncPhase_r ? ST_ARMED : ST_BUSY;
			ST_ARMED:
				if (syncOk)
					tranSt_nxt = ST_BUSY;
			ST_BUSY:
				if (lastPointDone)
					tranSt_nxt = ST_IDLE; // last point, not dwell end
			default:
				tranSt_nxt = ST_IDLE;
		endcase
		if (abortCmd)
			tranSt_nxt = ST_IDLE;
	end

	wire startNow = (tranSt_r != ST_BUSY) && (tranSt_nxt == ST_BUSY) && !abortCmd;

	// ==========================================================
	// a star always restarts the match, so a command cut short by a new
	// one is dropped rather than merged with it. letters of either case
	// are accepted; any other byte in the middle abandons the match.
	// the byte after the third letter decides between command and query.
	//
	// common command recogniser: star, three letters, optional '?'
	logic [2:0] comPos_r;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			comPos_r        <= 3'h0;
			commonCmdSeen   <= 1'b0;
			commonQuerySeen <= 1'b0;
		end else begin
			commonCmdSeen   <= 1'b0;
			commonQuerySeen <= 1'b0;
			if (cmdByteValid) begin
				if (cmdByte == CH_STAR)
					comPos_r <= 3'h1;
				else if (comPos_r >= 3'h1 && comPos_r <= 3'h3 && isLetter(cmdByte))
					comPos_r <= comPos_r + 3'h1;
				else if (comPos_r == 3'h4 && cmdByte == CH_QUERY) begin
					commonQuerySeen <= 1'b1;
					comPos_r        <= 3'h0;
				end else if (comPos_r == 3'h4) begin
					commonCmdSeen <= 1'b1;
					comPos_r      <= 3'h0;
				end else
					comPos_r <= 3'h0;
			end
		end
	end

	// ==========================================================
	// settings registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acqSrc_r    <= ACQ_IMMEDIATE;
			syncPhase_r <= 1'b0;
			phaseSet_r  <= PHASE_RST;
		end else if (apbWrite) begin
			if (hitCtrl) begin
				acqSrc_r    <= tssc_acq_t'(pwdata[CTRL_ACQ_LSB +: 2]);
				syncPhase_r <= pwdata[CTRL_SYNC_BIT];
			end
			if (hitPhase)
				phaseSet_r <= angleClamped;
		end
	end

	// trigger systems
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tranSt_r    <= ST_IDLE;
			acqArmed_r  <= 1'b0;
			acqBusy_r   <= 1'b0;
			phasePrev_r <= 9'h0;
		end else begin
			tranSt_r    <= tranSt_nxt;
			phasePrev_r <= phaseAccum;
			if (abortCmd) begin
				acqArmed_r <= 1'b0;
				acqBusy_r  <= 1'b0;
			end else begin
				if (initAcq && !acqArmed_r && !acqBusy_r)
					acqArmed_r <= 1'b1;
				else if (acqFires)
					acqArmed_r <= 1'b0;
				if (acqFires)
					acqBusy_r <= 1'b1;
				else if (acqCalcDone)
					acqBusy_r <= 1'b0; // results ready once calculations end
			end
		end
	end

	// engine strobes; trigger out marks the transient start
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			transientStart  <= 1'b0;
			transientCancel <= 1'b0;
			acqStart        <= 1'b0;
			triggerOut      <= 1'b0;
		end else begin
			transientStart  <= startNow;
			transientCancel <= abortCmd;
			acqStart        <= acqFires && !abortCmd;
			triggerOut      <= startNow;
		end
	end

	// ==========================================================
	// wait command: hold the bus while device work is outstanding
	// limitation: the engine only reports whether any command is pending,
	// so the hold ends on the first cycle in which nothing is pending and
	// neither system is busy; a command issued after the wait is not told
	// apart from one issued before it. a new wait set in the same cycle as
	// the release keeps the hold, since the set is tested first.
	wire waitWr = apbWrite && hitCom;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busHold <= 1'b0;
		end else begin
			if (waitWr && pwdata[0])
				busHold <= 1'b1;
			else if (busHold && !devCmdPending && tranSt_r != ST_BUSY && !acqBusy_r)
				busHold <= 1'b0;
		end
	end

	// ==========================================================
	// read mux and apb answer, zero wait states
	logic [1:0] repSt;
	always_comb begin
		case (tranSt_r)
			ST_IDLE:                 repSt = REP_IDLE;
			ST_AWAITING_EVENT_STATE: repSt = REP_WAIT;
			ST_ARMED:                repSt = REP_ARM;
			ST_BUSY:                 repSt = REP_BUSY;
			default:                 repSt = REP_IDLE;
		endcase
	end
	// status word assembled from the field positions
	logic [31:0] statWord;
	always_comb begin
		statWord                     = 32'h0;
		statWord[STAT_TRAN_LSB +: 2] = repSt;
		statWord[STAT_ACQ_BIT]       = acqArmed_r;
		statWord[STAT_ACQST]         = acqBusy_r;
		statWord[STAT_WAI_BIT]       = busHold;
	end
	wire [31:0] rdMux = hitCtrl  ? {29'h0, syncPhase_r, acqSrc_r} :
	                    hitPhase ? {{22{phaseSet_r[9]}}, phaseSet_r} :
	                    hitStat  ? statWord :
	                    hitCom   ? {31'h0, busHold} : 32'h0;

	// bus timing: setup at edge n, access with ready at edge n+1.
	// read data is taken at the setup edge and stands through the access
	// cycle, so the master samples settled flops and no address-to-data
	// path runs through the mux inside the access cycle. writes land at the
	// access edge, when psel, penable and pwrite are all high. ready never
	// stays high two cycles, so a back-to-back transfer gets a fresh setup.
	// ready is combinational-free: registered one cycle in setup
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable && !pready;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite)
				prdata <= rdMux;
		end
	end
endmodule : tssc_trigger_ctrl
`default_nettype wire

// ===== src/tssc_pkg.sv
package tssc_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_PHASE  = 8'h04;
	localparam logic [7:0] ADDR_CMD    = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_COMMON = 8'h10;
	// control field positions
	localparam int CTRL_ACQ_LSB  = 0;
	localparam int CTRL_SYNC_BIT = 2;
	// command bits
	localparam int CMD_INIT_TRAN = 0;
	localparam int CMD_INIT_ACQ  = 1;
	localparam int CMD_ABORT     = 2;
	localparam int CMD_BUS_TRG   = 3;
	localparam int CMD_TRIG_NOW  = 4;
	localparam int CMD_GET       = 5;
	// status field positions
	localparam int STAT_TRAN_LSB = 0;
	localparam int STAT_ACQ_BIT  = 3;
	localparam int STAT_ACQST    = 4;
	localparam int STAT_WAI_BIT  = 5;
	// phase limits, tenths ignored: whole degrees
	localparam logic signed [9:0] PHASE_MAX = 10'sd360;
	localparam logic signed [9:0] PHASE_MIN = -10'sd360;
	localparam logic signed [9:0] PHASE_RST = 10'sd0;
	localparam logic [8:0] FULL_TURN = 9'd360;
	// common command characters
	localparam logic [7:0] CH_STAR  = 8'h2a;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	// acquisition trigger sources
	typedef enum logic [1:0] {
		ACQ_IMMEDIATE                 = 2'h0,
		ACQ_PHASE_LOCKED_SOURCE       = 2'h1,
		ACQ_BUS                       = 2'h2,
		ACQ_TRIGGER_OUT_SIGNAL_SOURCE = 2'h3
	} tssc_acq_t;
	// transient trigger states, gray along idle-awaiting-armed-busy
	typedef enum logic [1:0] {
		ST_IDLE                 = 2'h0,
		ST_AWAITING_EVENT_STATE = 2'h1,
		ST_ARMED                = 2'h3,
		ST_BUSY                 = 2'h2
	} tssc_state_t;
	// reported state codes
	localparam logic [1:0] REP_IDLE = 2'h0;
	localparam logic [1:0] REP_ARM  = 2'h1;
	localparam logic [1:0] REP_BUSY = 2'h2;
	localparam logic [1:0] REP_WAIT = 2'h3;
endpackage : tssc_pkg

// ===== dv/tssc_trigger_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checks on the apb answer and output pulses
module tssc_trigger_ctrl_sva
	import tssc_pkg::*;
(
	// watched ports
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        cmdByteValid,
	input wire logic [7:0]  cmdByte,
	input wire logic        transientStart,
	input wire logic        triggerOut,
	input wire logic        busHold,
	input wire logic        commonCmdSeen,
	input wire logic        commonQuerySeen
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_ready_follows: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready held");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_start_drives_out: assert property (transientStart |-> triggerOut)
		else $error("start without trigger out");
	chk_start_single: assert property (transientStart |=> !transientStart)
		else $error("start pulse too long");
	chk_hold_cause: assert property ($rose(busHold) |->
		$past(psel && penable && pwrite && paddr == ADDR_COMMON && pwdata[0]))
		else $error("bus hold without wait write");
	chk_query_cause: assert property (commonQuerySeen |->
		$past(cmdByteValid && cmdByte == CH_QUERY))
		else $error("query flag without question mark");
	chk_cmd_cause: assert property (commonCmdSeen |->
		$past(cmdByteValid && cmdByte != CH_QUERY))
		else $error("command flag on question mark");
endmodule : tssc_trigger_ctrl_sva
`default_nettype wire

// ===== dv/tssc_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// phase and list engine beside the block
module tssc_engine_model
	import tssc_pkg::*;
(
	// control
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       transientStart,
	input  wire logic       acqStart,
	// answers
	output logic      [8:0] phaseAccum,
	output logic            lastPointDone,
	output logic            acqCalcDone
);
	logic [5:0] runCnt_r;
	logic [2:0] calcCnt_r;
	// list ends with a short final point so busy spans the whole list
	assign lastPointDone = (runCnt_r == 6'h01);
	assign acqCalcDone   = (calcCnt_r == 3'h1);
	// free running phase, one degree a cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phaseAccum <= 9'h000;
			runCnt_r   <= 6'h00;
			calcCnt_r  <= 3'h0;
		end else begin
			phaseAccum <= (phaseAccum == 9'h167) ? 9'h000 : phaseAccum + 9'h001;
			runCnt_r   <= transientStart ? 6'h28 : runCnt_r - {5'h00, |runCnt_r};
			calcCnt_r  <= acqStart ? 3'h5 : calcCnt_r - {2'h0, |calcCnt_r};
		end
	end
endmodule : tssc_engine_model
`default_nettype wire

// ===== dv/trigger_source_sync_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// register table, trigger flows, common bytes
module trigger_source_sync_control_test
	import tssc_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q;} tssc_row_t;
	logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, clr = 0;
	logic extTrigger = 0, devCmdPending = 0, cmdByteValid = 0;
	logic [7:0] paddr = 0, cmdByte = 0;
	logic [31:0] pwdata = 0, rd, prdata;
	logic [8:0] phaseAccum, startPhase, acqPhase;
	logic err;
	string cmdText = "*TRG\n*OPC?";
	logic pready, pslverr, transientStart, transientCancel, acqStart, triggerOut;
	logic lastPointDone, acqCalcDone, busHold, commonCmdSeen, commonQuerySeen;
	logic [4:0] seen;
	int num_errors = 0, n_tests = 0, k;
	tssc_row_t rows[8] = '{'{ADDR_CTRL, 1, 1}, '{ADDR_CTRL, 3, 3}, '{ADDR_CTRL, 6, 6},
		'{ADDR_PHASE, 32'h5a, 32'h5a}, '{ADDR_PHASE, 32'hfffffe98, 32'hfffffe98},
		'{ADDR_PHASE, 32'h190, 32'h168}, '{ADDR_PHASE, 32'hfffffe70, 32'hfffffe98},
		'{8'h20, 32'hff, 32'h0}};
	always #5 clock = ~clock;
	tssc_trigger_ctrl dut (.*);
	tssc_engine_model eng (.clock(clock), .rst(rst), .transientStart(transientStart),
		.acqStart(acqStart), .phaseAccum(phaseAccum), .lastPointDone(lastPointDone),
		.acqCalcDone(acqCalcDone));
	// sticky pulse flags, since pulses last one cycle only
	always @(posedge clock) begin
		seen <= clr ? 5'h00 : seen | {commonQuerySeen, commonCmdSeen, acqStart,
			transientCancel, transientStart & triggerOut};
		if (transientStart) startPhase <= phaseAccum;
		if (acqStart) acqPhase <= phaseAccum;
	end
	task test_done();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin num_errors++; test_done(); end
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
		@(posedge clock);
	endtask : apb
	task automatic waitst(input logic [1:0] s);
		int n;
		for (n = 0; n < 200; n++) begin
			apb(ADDR_STATUS, 0, 0);
			if (rd[1:0] === s) break;
		end
		if (n == 200) begin num_errors++; test_done(); end
	endtask : waitst
	task pulse_clr();
		clr <= 1;
		@(posedge clock);
		clr <= 0;
	endtask : pulse_clr
	task send(input logic [7:0] b);
		cmdByteValid <= 1; cmdByte <= b;
		@(posedge clock);
		cmdByteValid <= 0;
		@(posedge clock);
	endtask : send
	initial begin
		repeat (10) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		apb(ADDR_CTRL, 0, 0); chk(rd, 0);
		apb(ADDR_PHASE, 0, 0); chk(rd, 0);
		apb(ADDR_STATUS, 0, 0); chk(rd, 0);
		foreach (rows[i]) begin
			apb(rows[i].a, 1, rows[i].d);
			chk(err, rows[i].a > ADDR_COMMON);
			apb(rows[i].a, 0, 0); chk(rd, rows[i].q);
		end
		$display("test registers done");
		apb(ADDR_CTRL, 1, 0); apb(ADDR_PHASE, 1, 0); pulse_clr();
		apb(ADDR_CMD, 1, 1); apb(ADDR_CMD, 1, 1);
		apb(ADDR_STATUS, 0, 0); chk(rd, REP_WAIT);
		apb(ADDR_CMD, 1, 32'h10); waitst(REP_BUSY);
		chk(seen[0], 1);
		waitst(REP_IDLE);
		apb(ADDR_CMD, 1, 1); apb(ADDR_CMD, 1, 32'h10); apb(ADDR_CMD, 1, 4);
		apb(ADDR_STATUS, 0, 0); chk({rd[1:0], seen[1]}, 3'h1);
		$display("test immediate done");
		apb(ADDR_CTRL, 1, 4); apb(ADDR_PHASE, 1, 32'hfffffef2); apb(ADDR_CMD, 1, 1);
		for (k = 0; k < 400 && phaseAccum !== 9'h0c8; k++) @(posedge clock);
		if (k == 400) num_errors++;
		apb(ADDR_CMD, 1, 32'h10);
		apb(ADDR_STATUS, 0, 0); chk(rd[1:0], REP_ARM);
		waitst(REP_BUSY);
		chk(startPhase >= 9'h05a && startPhase <= 9'h05f, 1);
		waitst(REP_IDLE);
		apb(ADDR_CTRL, 1, 2); pulse_clr();
		apb(ADDR_CMD, 1, 2); apb(ADDR_CMD, 1, 1); apb(ADDR_CMD, 1, 8);
		apb(ADDR_STATUS, 0, 0); chk({rd[1:0], seen[2]}, 3'h7);
		apb(ADDR_CMD, 1, 32'h20); waitst(REP_BUSY);
		waitst(REP_IDLE);
		apb(ADDR_CTRL, 1, 3); pulse_clr(); apb(ADDR_CMD, 1, 2); apb(ADDR_CMD, 1, 1);
		extTrigger <= 1;
		@(posedge clock);
		extTrigger <= 0;
		waitst(REP_BUSY);
		chk(seen[2], 1);
		waitst(REP_IDLE);
		apb(ADDR_CTRL, 1, 1); pulse_clr(); apb(ADDR_CMD, 1, 2);
		for (k = 0; k < 400 && seen[2] !== 1'b1; k++) @(posedge clock);
		chk(seen[2], 1);
		chk(acqPhase >= 9'h05a && acqPhase <= 9'h05f, 1);
		repeat (8) @(posedge clock);
		apb(ADDR_CTRL, 1, 0); pulse_clr(); apb(ADDR_CMD, 1, 2);
		repeat (2) @(posedge clock);
		chk(seen[2], 1);
		apb(ADDR_STATUS, 0, 0); chk(rd[4], 1);
		repeat (5) @(posedge clock);
		apb(ADDR_STATUS, 0, 0); chk(rd[4], 0);
		$display("test triggers done");
		devCmdPending <= 1;
		apb(ADDR_COMMON, 1, 1); apb(ADDR_COMMON, 0, 0); chk(rd, 1);
		devCmdPending <= 0;
		for (int j = 0; j < 20 && rd !== 0; j++) apb(ADDR_COMMON, 0, 0);
		chk(rd, 0);
		pulse_clr();
		for (int j = 0; j < cmdText.len(); j++) send(cmdText[j]);
		@(posedge clock);
		chk(seen[4:3], 2'h3);
		$display("test common done");
		test_done();
	end
endmodule : trigger_source_sync_control_test
bind tssc_trigger_ctrl tssc_trigger_ctrl_sva sva (.*);
`default_nettype wire
